/* sdi_device.sv */
// Converter front end: strobe handling, frame pulse, serial capture, code latch
//
// Behaviour
// (RULE1) Words are MSB first, two's complement
// (RULE2) Strobe fall loads previous word when unheld
// (RULE3) Strobe may be fully asynchronous
// (RULE4) Data sampled on bit clock rising edges
// (RULE5) Host spaces strobes 24 or 40 periods
// (RULE6) Strobe triggers frame; frame moves on rises
// (RULE7) Polarity select sets frame idle and active
// (RULE8) Frame pulse lasts one bit clock period
// (RULE9) Short mode captures 16 bits, ignores rest
// (RULE10) Short words get two low zero bits
// (RULE11) Long mode captures 18 bits, ignores rest
// (RULE12) Chained mode captures one 32-bit word
// (RULE13) Chained mode needs short length select
// (RULE14) Hold keeps outputs, still frames and captures
// (RULE15) Zero reset ignores data; two strobes zero
// (RULE16) Host keeps hold low around zero reset
// (RULE17) After zero reset, first strobe loads zero
// (RULE18) Works from power-up without zero reset
// (RULE19) Supports 500 kHz strobe rate
// (RULE20) Chained: first half A, second half B
// (RULE21) Unchained: both channels shift in parallel
// (RULE22) Counting starts on rise after frame pulse
`default_nettype none
module sdi_device
    import sdi_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Link to the host
    sdi_link_if.device link,
    // Converter codes
    output logic [17:0] dac_code_a,
    output logic [17:0] dac_code_b,
    // Status
    output logic load_pulse,
    output logic capture_busy
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [PIN_N-1:0] pin_meta;
    logic [PIN_N-1:0] pin_sync;
    logic bclk_prev;
    logic stb_prev;

    // Every pin is foreign to mclk, so all pass two flops first (RULE3)
    always_ff @(posedge mclk) begin
        pin_meta <= {link.serial_data_in_b, link.serial_data_in_a, link.zero_reset_n, link.latch_hold,
                     link.chained_word_select, link.word_length_select, link.frame_polarity_select,
                     link.convert_strobe_in, link.bit_clock_in};
        pin_sync <= pin_meta;
    end

    // Edge history taken from the second stage only
    always_ff @(posedge mclk) begin
        if (srst) begin
            bclk_prev <= 1'b0;
            stb_prev <= 1'b1;
        end else begin
            bclk_prev <= pin_sync[PIN_BCLK];
            stb_prev <= pin_sync[PIN_STB];
        end
    end

    logic bclk_rise;
    logic stb_fall;

    // Rising bit clock and falling strobe events
    assign bclk_rise = pin_sync[PIN_BCLK] & ~bclk_prev; // RULE4
    assign stb_fall = ~pin_sync[PIN_STB] & stb_prev; // RULE3

    ////////////////////////////////////////////////////////////////////////
    // Capture sequence

    sdi_dev_state_e state;
    logic [5:0] word_len;
    logic [5:0] bit_cnt;
    logic chain_q;

    // A strobe always restarts the sequence, even mid-word
    always_ff @(posedge mclk) begin
        if (srst) begin
            state <= SDI_D_IDLE;
        end else if (stb_fall) begin
            state <= SDI_D_PEND; // RULE6
        end else if (bclk_rise) begin
            case (state)
                SDI_D_PEND: begin
                    state <= SDI_D_PULSE;
                end
                SDI_D_PULSE: begin
                    state <= SDI_D_SHIFT; // RULE22
                end
                SDI_D_SHIFT: begin
                    if (bit_cnt == word_len - 6'h01) begin
                        state <= SDI_D_IDLE; // RULE9 RULE11 RULE19
                    end
                end
                default: begin
                    state <= SDI_D_IDLE; // RULE18
                end
            endcase
        end
    end

    // Mode is taken at the strobe and kept for the whole word
    always_ff @(posedge mclk) begin
        if (srst) begin
            word_len <= LEN_LONG;
            chain_q <= 1'b0;
        end else if (stb_fall) begin
            chain_q <= pin_sync[PIN_CHAIN];
            if (pin_sync[PIN_CHAIN]) begin
                word_len <= LEN_CHAIN; // RULE12
            end else if (pin_sync[PIN_WLEN]) begin
                word_len <= LEN_SHORT; // RULE9
            end else begin
                word_len <= LEN_LONG; // RULE11
            end
        end
    end

    // Bits counted only in the shift phase
    always_ff @(posedge mclk) begin
        if (srst || stb_fall) begin
            bit_cnt <= 6'h00;
        end else if (bclk_rise && state == SDI_D_SHIFT) begin
            bit_cnt <= bit_cnt + 6'h01; // RULE22
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shift registers

    logic [31:0] shift_a;
    logic [17:0] shift_b;

    // Cleared at each strobe so zero reset flushes in two strobes
    always_ff @(posedge mclk) begin
        if (srst || stb_fall) begin
            shift_a <= 32'h0000_0000;
            shift_b <= 18'h0_0000;
        end else if (!pin_sync[PIN_ZRST_N]) begin
            shift_a <= 32'h0000_0000; // RULE15
            shift_b <= 18'h0_0000;
        end else if (bclk_rise && state == SDI_D_SHIFT) begin
            shift_a <= {shift_a[30:0], pin_sync[PIN_DA]}; // RULE1 RULE4 RULE21
            shift_b <= {shift_b[16:0], pin_sync[PIN_DB]}; // RULE21
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Converter latch

    // Word from the previous strobe goes out on this one
    always_ff @(posedge mclk) begin
        if (srst) begin
            dac_code_a <= CODE_ZERO;
            dac_code_b <= CODE_ZERO;
        end else if (stb_fall && !pin_sync[PIN_HOLD]) begin // RULE2 RULE14
            if (chain_q) begin
                dac_code_a <= {shift_a[31:16], 2'b00}; // RULE20 RULE10
                dac_code_b <= {shift_a[15:0], 2'b00}; // RULE20
            end else if (word_len == LEN_SHORT) begin
                dac_code_a <= {shift_a[15:0], 2'b00}; // RULE10
                dac_code_b <= {shift_b[15:0], 2'b00};
            end else begin
                dac_code_a <= shift_a[17:0]; // RULE17
                dac_code_b <= shift_b;
            end
        end
    end

    // Load marker and capture status for the user side
    always_ff @(posedge mclk) begin
        if (srst) begin
            load_pulse <= 1'b0;
            capture_busy <= 1'b0;
        end else begin
            load_pulse <= stb_fall & ~pin_sync[PIN_HOLD];
            capture_busy <= stb_fall | (state != SDI_D_IDLE);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame output

    // Changes only on a bit clock rise; active for one whole period
    always_ff @(posedge mclk) begin
        if (srst) begin
            link.frame_sync <= FRAME_RESET;
        end else if (bclk_rise) begin
            if (state == SDI_D_PEND) begin
                link.frame_sync <= pin_sync[PIN_POL]; // RULE6 RULE7 RULE8
            end else begin
                link.frame_sync <= ~pin_sync[PIN_POL]; // RULE7
            end
        end
    end

endmodule
`default_nettype wire

/* sdi_host.sv */
// Host serial port end: bit clock divider, strobes, word shifting, strap levels
`default_nettype none
module sdi_host
    import sdi_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Link to the converter
    sdi_link_if.host link,
    // Transfer request
    input wire logic send_req,
    input wire logic [17:0] send_code_a,
    input wire logic [17:0] send_code_b,
    output logic send_ready,
    // Configuration levels
    input wire logic cfg_word_short,
    input wire logic cfg_chain,
    input wire logic cfg_frame_high,
    input wire logic cfg_hold,
    input wire logic cfg_zero
);

    ////////////////////////////////////////////////////////////////////////
    // Bit clock divider

    logic [3:0] div_cnt;
    logic bclk_rise;
    logic bclk_fall;

    // Free running clock, toggled every half period
    always_ff @(posedge mclk) begin
        if (srst) begin
            div_cnt <= 4'h0;
            link.bit_clock_in <= 1'b0;
        end else if (div_cnt == BCLK_HALF_CYC - 4'h1) begin
            div_cnt <= 4'h0;
            link.bit_clock_in <= ~link.bit_clock_in;
        end else begin
            div_cnt <= div_cnt + 4'h1;
        end
    end

    assign bclk_rise = (div_cnt == BCLK_HALF_CYC - 4'h1) & ~link.bit_clock_in;
    assign bclk_fall = (div_cnt == BCLK_HALF_CYC - 4'h1) & link.bit_clock_in;

    ////////////////////////////////////////////////////////////////////////
    // Strap levels

    // Chained mode forces short words; zeroing forces hold low
    always_ff @(posedge mclk) begin
        if (srst) begin
            link.frame_polarity_select <= 1'b0;
            link.word_length_select <= 1'b0;
            link.chained_word_select <= 1'b0;
            link.latch_hold <= 1'b0;
            link.zero_reset_n <= 1'b1;
        end else begin
            link.frame_polarity_select <= cfg_frame_high;
            link.word_length_select <= cfg_word_short | cfg_chain; // RULE13
            link.chained_word_select <= cfg_chain;
            link.latch_hold <= cfg_hold & ~cfg_zero; // RULE16
            link.zero_reset_n <= ~cfg_zero;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame detection

    logic frame_meta;
    logic frame_sync_q;
    logic frame_act_prev;
    logic frame_act;
    logic frame_seen;

    // Frame is from the other end, so two flops before use
    always_ff @(posedge mclk) begin
        frame_meta <= link.frame_sync;
        frame_sync_q <= frame_meta;
    end

    assign frame_act = frame_sync_q ~^ link.frame_polarity_select;

    ////////////////////////////////////////////////////////////////////////
    // Transfer sequence

    sdi_host_state_e state;
    logic [31:0] out_shift;
    logic [17:0] out_b; // Own word for line b, two 18-bit words do not fit in 32 bits
    logic [5:0] out_len;
    logic [5:0] sent_cnt;
    logic [5:0] gap_min;
    logic [5:0] gap_cnt;
    logic [3:0] stb_cnt;

    // Frame start is remembered until the host enters the strobe state again
    always_ff @(posedge mclk) begin
        if (srst) begin
            frame_act_prev <= 1'b0;
            frame_seen <= 1'b0;
        end else begin
            frame_act_prev <= frame_act;
            if (frame_act && !frame_act_prev) begin
                frame_seen <= 1'b1;
            end else if (state == SDI_H_STROBE) begin
                frame_seen <= 1'b0;
            end
        end
    end

    // Strobe, wait for frame, shift MSB first on falling edges, then keep the gap
    always_ff @(posedge mclk) begin
        if (srst) begin
            state <= SDI_H_IDLE;
            link.convert_strobe_in <= 1'b1;
            link.serial_data_in_a <= 1'b0;
            link.serial_data_in_b <= 1'b0;
            out_shift <= 32'h0000_0000;
            out_b <= 18'h0_0000;
            out_len <= LEN_LONG;
            gap_min <= GAP_NORMAL;
            sent_cnt <= 6'h00;
            stb_cnt <= 4'h0;
            send_ready <= 1'b0;
        end else begin
            case (state)
                SDI_H_IDLE: begin
                    send_ready <= 1'b1;
                    if (send_req) begin
                        send_ready <= 1'b0;
                        state <= SDI_H_STROBE;
                        link.convert_strobe_in <= 1'b0;
                        stb_cnt <= 4'h0;
                        sent_cnt <= 6'h00;
                        if (cfg_chain) begin
                            out_shift <= {send_code_a[17:2], send_code_b[17:2]}; // RULE1
                            out_b <= 18'h0_0000;
                            out_len <= LEN_CHAIN;
                            gap_min <= GAP_CHAIN; // RULE5
                        end else if (cfg_word_short) begin
                            out_shift <= {send_code_a[17:2], 16'h0000};
                            out_b <= {send_code_b[17:2], 2'b00};
                            out_len <= LEN_SHORT;
                            gap_min <= GAP_NORMAL; // RULE5
                        end else begin
                            out_shift <= {send_code_a, 14'h0000};
                            out_b <= send_code_b;
                            out_len <= LEN_LONG;
                            gap_min <= GAP_NORMAL;
                        end
                    end
                end
                SDI_H_STROBE: begin
                    stb_cnt <= stb_cnt + 4'h1;
                    if (stb_cnt == STROBE_LOW_CYC - 4'h1) begin
                        link.convert_strobe_in <= 1'b1;
                        state <= SDI_H_WAIT;
                    end
                end
                SDI_H_WAIT: begin
                    if (bclk_fall && frame_seen) begin
                        state <= SDI_H_SEND;
                        sent_cnt <= 6'h01;
                        link.serial_data_in_a <= out_shift[31];
                        link.serial_data_in_b <= (out_len == LEN_CHAIN) ? out_shift[31] : out_b[17];
                        out_shift <= {out_shift[30:0], 1'b0};
                        out_b <= {out_b[16:0], 1'b0};
                    end
                end
                SDI_H_SEND: begin
                    if (bclk_fall) begin
                        if (sent_cnt == out_len) begin
                            link.serial_data_in_a <= 1'b0;
                            link.serial_data_in_b <= 1'b0;
                            state <= SDI_H_GAP;
                        end else begin
                            sent_cnt <= sent_cnt + 6'h01;
                            link.serial_data_in_a <= out_shift[31];
                            link.serial_data_in_b <= (out_len == LEN_CHAIN) ? out_shift[31] : out_b[17];
                            out_shift <= {out_shift[30:0], 1'b0};
                            out_b <= {out_b[16:0], 1'b0};
                        end
                    end
                end
                SDI_H_GAP: begin
                    if (gap_cnt > gap_min) begin
                        state <= SDI_H_IDLE; // RULE5
                    end
                end
                default: begin
                    state <= SDI_H_IDLE;
                end
            endcase
        end
    end

    // Bit clock periods since the strobe, saturating
    always_ff @(posedge mclk) begin
        if (srst || state == SDI_H_STROBE) begin
            gap_cnt <= 6'h00;
        end else if (bclk_rise && gap_cnt != 6'h3f) begin
            gap_cnt <= gap_cnt + 6'h01;
        end
    end

endmodule
`default_nettype wire

/* sdi_link_assertions.sv */
// Link checker: frame timing, strobe spacing and strap combinations
`default_nettype none
module sdi_link_assertions
    import sdi_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Link wires
    input wire logic bit_clock_in,
    input wire logic convert_strobe_in,
    input wire logic frame_sync,
    input wire logic serial_data_in_a,
    input wire logic serial_data_in_b,
    input wire logic frame_polarity_select,
    input wire logic word_length_select,
    input wire logic chained_word_select,
    input wire logic latch_hold,
    input wire logic zero_reset_n
);
    localparam int FRAME_MAX = 20;
    localparam logic [9:0] SPACE_NORM = 10'(GAP_NORMAL * 2 * BCLK_HALF_CYC);
    localparam logic [9:0] SPACE_CHAIN = 10'(GAP_CHAIN * 2 * BCLK_HALF_CYC);
    logic [9:0] since_stb;
    logic chain_at;

    default clocking @(posedge mclk); endclocking
    default disable iff (srst);

    ////////////////////////////////////////////////////////////////////////
    // Cycles since the last strobe, saturating so an idle link never wraps
    always_ff @(posedge mclk) begin
        if (srst) begin
            since_stb <= 10'h3ff;
            chain_at <= 1'b0;
        end else if ($fell(convert_strobe_in)) begin
            since_stb <= 10'h000;
            chain_at <= chained_word_select;
        end else if (since_stb != 10'h3ff) begin
            since_stb <= since_stb + 10'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame going to its active level
    sequence frame_start_s;
        $changed(frame_sync) && frame_sync == frame_polarity_select;
    endsequence

    frame_on_rise_a: assert property ($changed(frame_sync) |->
        (bit_clock_in || $past(bit_clock_in)) && !$past(bit_clock_in, 5))
        else $error("frame moved away from a bit clock rise");
    frame_width_a: assert property (frame_start_s |=> $stable(frame_sync)[*7] ##1 $changed(frame_sync))
        else $error("frame pulse not one bit period wide");
    frame_cause_a: assert property (frame_start_s |-> since_stb inside {[1:18]})
        else $error("frame pulse without a strobe");
    strobe_frame_a: assert property ($fell(convert_strobe_in) |-> ##[1:FRAME_MAX] frame_start_s)
        else $error("strobe gave no frame pulse");
    frame_idle_a: assert property (since_stb >= 10'h020 && $past(frame_polarity_select, 16) == frame_polarity_select
        |-> frame_sync != frame_polarity_select)
        else $error("frame not at idle level");
    data_steady_a: assert property ($changed(serial_data_in_a) || $changed(serial_data_in_b) |-> !bit_clock_in)
        else $error("data moved while bit clock high");
    strobe_space_a: assert property ($fell(convert_strobe_in) |->
        since_stb >= (chain_at ? SPACE_CHAIN : SPACE_NORM) - 10'h001)
        else $error("strobes too close");
    chain_short_a: assert property (chained_word_select |-> word_length_select)
        else $error("chained word without short length");
    hold_zero_a: assert property (!zero_reset_n |-> !latch_hold)
        else $error("hold high during zero reset");
endmodule
`default_nettype wire

/* sdi_link_if.sv */
// Link wires between the host serial port and the converter front end
`default_nettype none
interface sdi_link_if;
    logic bit_clock_in;
    logic convert_strobe_in;
    logic frame_sync;
    logic serial_data_in_a;
    logic serial_data_in_b;
    logic frame_polarity_select;
    logic word_length_select;
    logic chained_word_select;
    logic latch_hold;
    logic zero_reset_n;
    modport device (
        input bit_clock_in, convert_strobe_in, serial_data_in_a, serial_data_in_b,
        input frame_polarity_select, word_length_select, chained_word_select,
        input latch_hold, zero_reset_n,
        output frame_sync
    );
    modport host (
        output bit_clock_in, convert_strobe_in, serial_data_in_a, serial_data_in_b,
        output frame_polarity_select, word_length_select, chained_word_select,
        output latch_hold, zero_reset_n,
        input frame_sync
    );
endinterface
`default_nettype wire

/* sdi_pkg.sv */
// Shared constants and types for the serial converter input link
`default_nettype none
package sdi_pkg;
    // Local clock
    localparam int unsigned MCLK_HZ = 50_000_000;
    localparam int unsigned MCLK_NS = 20;
    // Fastest bit clock the device side accepts
    localparam int unsigned BCLK_MAX_HZ = 12_000_000;
    // Host bit clock half period in mclk cycles (160 ns period)
    localparam logic [3:0] BCLK_HALF_CYC = 4'h4;
    // Width of the convert strobe low pulse from the host
    localparam int unsigned STROBE_LOW_NS = 80;
    localparam logic [3:0] STROBE_LOW_CYC = 4'((STROBE_LOW_NS + MCLK_NS - 1) / MCLK_NS);
    // Word lengths in bits
    localparam logic [5:0] LEN_SHORT = 6'h10;
    localparam logic [5:0] LEN_LONG = 6'h12;
    localparam logic [5:0] LEN_CHAIN = 6'h20;
    // Least strobe spacing in bit clock periods
    localparam logic [5:0] GAP_NORMAL = 6'h18;
    localparam logic [5:0] GAP_CHAIN = 6'h28;
    // Converter code width and its zero code
    localparam int unsigned CODE_W = 18;
    localparam logic [17:0] CODE_ZERO = 18'h0_0000;
    // Frame output level at reset (select low means idle high)
    localparam logic FRAME_RESET = 1'b1;
    // Synchronised pin vector positions in the device
    localparam int unsigned PIN_BCLK = 0;
    localparam int unsigned PIN_STB = 1;
    localparam int unsigned PIN_POL = 2;
    localparam int unsigned PIN_WLEN = 3;
    localparam int unsigned PIN_CHAIN = 4;
    localparam int unsigned PIN_HOLD = 5;
    localparam int unsigned PIN_ZRST_N = 6;
    localparam int unsigned PIN_DA = 7;
    localparam int unsigned PIN_DB = 8;
    localparam int unsigned PIN_N = 9;
    // Device capture sequence
    typedef enum logic [1:0] {
        SDI_D_IDLE = 2'b00,
        SDI_D_PEND = 2'b01,
        SDI_D_PULSE = 2'b11,
        SDI_D_SHIFT = 2'b10
    } sdi_dev_state_e;
    // Host transfer sequence
    typedef enum logic [2:0] {
        SDI_H_IDLE = 3'b000,
        SDI_H_STROBE = 3'b001,
        SDI_H_WAIT = 3'b011,
        SDI_H_SEND = 3'b010,
        SDI_H_GAP = 3'b110
    } sdi_host_state_e;
endpackage
`default_nettype wire

/* serial_dac_input_interface_test.sv */
// Bench: host and converter ends joined over the link, codes checked
`default_nettype none
module serial_dac_input_interface_test
    import sdi_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int WATCH_NS = 40 * 1200 * 20;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic send_req = 1'b0;
    logic [17:0] code_a = 18'h0_0000;
    logic [17:0] code_b = 18'h0_0000;
    logic cfg_short = 1'b0;
    logic cfg_chain = 1'b0;
    logic cfg_high = 1'b0;
    logic cfg_hold = 1'b0;
    logic cfg_zero = 1'b0;
    logic [17:0] dac_code_a;
    logic [17:0] dac_code_b;
    logic load_pulse;
    logic capture_busy;
    logic send_ready;
    logic [31:0] rnd = 32'h0001_08dc;
    logic [17:0] cur_a = 18'h0_0000;
    logic [17:0] cur_b = 18'h0_0000;
    logic [17:0] nxt_a = 18'h0_0000;
    logic [17:0] nxt_b = 18'h0_0000;
    logic cur_ok = 1'b1;
    logic nxt_ok = 1'b0;
    int n_fail = 0;
    int comparisons = 0;

    ////////////////////////////////////////////////////////////////////////
    // Both ends and the checker on one link
    sdi_link_if link();
    sdi_device i_sdi_device (.mclk(mclk), .srst(srst), .link(link), .dac_code_a(dac_code_a),
        .dac_code_b(dac_code_b), .load_pulse(load_pulse), .capture_busy(capture_busy));
    sdi_host i_sdi_host (.mclk(mclk), .srst(srst), .link(link), .send_req(send_req), .send_code_a(code_a),
        .send_code_b(code_b), .send_ready(send_ready), .cfg_word_short(cfg_short), .cfg_chain(cfg_chain),
        .cfg_frame_high(cfg_high), .cfg_hold(cfg_hold), .cfg_zero(cfg_zero));
    sdi_link_assertions i_sdi_link_assertions (.mclk(mclk), .srst(srst), .bit_clock_in(link.bit_clock_in),
        .convert_strobe_in(link.convert_strobe_in), .frame_sync(link.frame_sync),
        .serial_data_in_a(link.serial_data_in_a), .serial_data_in_b(link.serial_data_in_b),
        .frame_polarity_select(link.frame_polarity_select), .word_length_select(link.word_length_select),
        .chained_word_select(link.chained_word_select), .latch_hold(link.latch_hold),
        .zero_reset_n(link.zero_reset_n));

    ////////////////////////////////////////////////////////////////////////
    // Clock and watchdog
    initial begin
        forever #10 mclk = ~mclk;
    end
    initial begin
        #(WATCH_NS);
        n_fail++;
        $display("unexpected at %0t: watchdog expired", $time);
        results();
    end

    ////////////////////////////////////////////////////////////////////////
    // Random source and expected converter code
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // Short words keep the top 16 bits and gain two low zeros
    function automatic logic [17:0] shape(input logic [17:0] v, input logic short_m);
        return short_m ? {v[17:2], 2'b00} : v;
    endfunction

    task automatic check(input logic [17:0] got, input logic [17:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Straps settle well before the next strobe; a new polarity reaches the frame only at a bit clock rise
    task automatic set_mode(input logic s, input logic c, input logic h, input logic hold, input logic z);
        @(negedge mclk);
        cfg_short = s;
        cfg_chain = c;
        cfg_high = h;
        cfg_hold = hold;
        cfg_zero = z;
        repeat (16) @(negedge mclk);
        if (z) begin
            nxt_ok = 1'b0;
        end
    endtask

    // One strobe: the codes take the word of the strobe before
    task automatic xfer(input logic [17:0] a, input logic [17:0] b);
        int n;
        logic saw;
        logic busy;
        n = 0;
        saw = 1'b0;
        busy = 1'b0;
        while (send_ready !== 1'b1 && n < 1000) begin
            @(negedge mclk);
            n++;
        end
        code_a = a;
        code_b = b;
        send_req = 1'b1;
        @(negedge mclk);
        send_req = 1'b0;
        repeat (2) @(negedge mclk);
        n = 0;
        while (send_ready !== 1'b1 && n < 1000) begin
            saw = saw | (load_pulse === 1'b1);
            busy = busy | (capture_busy === 1'b1);
            @(negedge mclk);
            n++;
        end
        if (n >= 1000) begin
            n_fail++;
            $display("unexpected at %0t: host never ready again", $time);
        end
        check(18'(saw), 18'(!cfg_hold), "load pulse");
        check(18'(busy), 18'h0_0001, "busy during word");
        check(18'(capture_busy), 18'h0_0000, "busy after word");
        if (!cfg_hold) begin
            cur_a = nxt_a;
            cur_b = nxt_b;
            cur_ok = nxt_ok;
        end
        if (cur_ok) begin
            check(dac_code_a, cur_a, "channel a");
            check(dac_code_b, cur_b, "channel b");
        end
        nxt_a = cfg_zero ? 18'h0_0000 : shape(a, cfg_short);
        nxt_b = cfg_zero ? 18'h0_0000 : shape(b, cfg_short);
        nxt_ok = 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence: every mode and polarity, hold, then zero reset
    initial begin
        repeat (20) @(negedge mclk);
        srst = 1'b0;
        repeat (4) @(negedge mclk);
        for (int m = 0; m < 6; m++) begin
            set_mode(m % 3 != 0, m % 3 == 2, m >= 3, 1'b0, 1'b0);
            for (int i = 0; i < 3; i++) begin
                rnd = lfsr(rnd);
                xfer(i == 0 ? 18'h2_0000 : rnd[17:0], i == 0 ? 18'h1_ffff : rnd[31:14]);
            end
            $display("test mode %0d done at %0t", m, $time);
        end
        set_mode(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
        xfer(18'h1_5554, 18'h2_aaa8);
        set_mode(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        xfer(18'h0_0004, 18'h3_fffc);
        $display("test hold done at %0t", $time);
        set_mode(1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
        for (int i = 0; i < 5; i++) begin
            if (i == 2) begin
                set_mode(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
            end
            rnd = lfsr(rnd);
            xfer(rnd[17:0], rnd[31:14]);
        end
        $display("test zero done at %0t", $time);
        results();
    end
endmodule
`default_nettype wire
